// ===== hw/fp_unit_tag_status_control_regs.sv
// tag word, status word and mode control word of the floating point unit, with an AXI4-Lite slave
// assumes the execution core drives push, pop, result, exception and condition code strobes on aclk
`timescale 1ns/100ps

module fp_unit_tag_status_control_regs
    import fpu_regs_pkg::*;
(
    input  wire logic               aclk,             // core clock
    input  wire logic               aresetn,          // synchronous reset, active low
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,     // write address
    input  wire logic               s_axi_awvalid,    // write address valid
    output logic                    s_axi_awready,    // write address ready
    input  wire logic [DATA_W-1:0]  s_axi_wdata,      // write data
    input  wire logic [3:0]         s_axi_wstrb,      // write byte strobes
    input  wire logic               s_axi_wvalid,     // write data valid
    output logic                    s_axi_wready,     // write data ready
    output logic [1:0]              s_axi_bresp,      // write response
    output logic                    s_axi_bvalid,     // write response valid
    input  wire logic               s_axi_bready,     // write response ready
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,     // read address
    input  wire logic               s_axi_arvalid,    // read address valid
    output logic                    s_axi_arready,    // read address ready
    output logic [DATA_W-1:0]       s_axi_rdata,      // read data
    output logic [1:0]              s_axi_rresp,      // read response
    output logic                    s_axi_rvalid,     // read data valid
    input  wire logic               s_axi_rready,     // read data ready
    input  wire logic               push_valid,       // load onto a new stack top
    input  wire logic               pop_valid,        // pop the stack top
    input  wire logic               result_valid,     // overwrite a stack slot with a result
    input  wire logic [IDX_W-1:0]   result_slot,      // slot relative to the stack top
    input  wire logic [OPND_W-1:0]  operand,          // value of the push or result
    input  wire logic               exc_valid,        // exceptions detected this cycle
    input  wire logic [EXC_W-1:0]   exc_flags,        // exception flags, status layout
    input  wire logic               cc_valid,         // condition code update
    input  wire logic [3:0]         cc_value,         // new condition codes 3..0
    output logic                    trap_req,         // one-cycle trap report to the core
    output logic [1:0]              rounding_select,  // active rounding mode
    output logic [1:0]              precision_select, // active mantissa precision
    output logic [EXC_W-1:0]        exc_mask,         // active exception masks
    output logic [IDX_W-1:0]        stack_top,        // physical stack top register
    output logic [REG_W-1:0]        tag_word,         // current tag word
    output logic [REG_W-1:0]        status_word,      // current status word
    output logic                    irq               // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic                awready_ff,  nxt_awready;
    logic                wready_ff,   nxt_wready;
    logic                aw_held_ff,  nxt_aw_held;
    logic [ADDR_W-1:0]   aw_addr_ff,  nxt_aw_addr;
    logic                w_held_ff,   nxt_w_held;
    logic [DATA_W-1:0]   w_data_ff,   nxt_w_data;
    logic [3:0]          w_strb_ff,   nxt_w_strb;
    logic                bvalid_ff,   nxt_bvalid;
    logic [1:0]          bresp_ff,    nxt_bresp;
    logic                arready_ff,  nxt_arready;
    logic                rvalid_ff,   nxt_rvalid;
    logic [DATA_W-1:0]   rdata_ff,    nxt_rdata;
    logic [1:0]          rresp_ff,    nxt_rresp;
    logic [REG_W-1:0]    tag_ff,      nxt_tag;
    logic [3:0]          cc_ff,       nxt_cc;
    logic [IDX_W-1:0]    top_ff,      nxt_top;
    logic                es_ff,       nxt_es;
    logic                sf_ff,       nxt_sf;
    logic [EXC_W-1:0]    exc_ff,      nxt_exc;
    logic [REG_W-1:0]    mode_ff,     nxt_mode;
    logic [REG_W-1:0]    status_ff,   nxt_status;
    logic                trap_ff,     nxt_trap;
    logic [IRQ_W-1:0]    irq_stat_ff, nxt_irq_stat;
    logic [IRQ_W-1:0]    irq_mask_ff, nxt_irq_mask;
    logic                irq_ff,      nxt_irq;

    ////////////////////////////////////////////////////////////////////////////////
    // operand class and stack events
    tag_class_e          load_class;
    logic [IDX_W-1:0]    push_slot;
    logic [IDX_W-1:0]    res_slot;
    logic                push_fault;
    logic                pop_fault;
    logic                stack_err;
    logic [EXC_W-1:0]    hw_exc;
    logic [EXC_W-1:0]    cur_mask;
    logic                unmasked;
    logic                masked_only;

    tag_classifier tag_classifier_inst (
        .operand   (operand),
        .tag_class (load_class)
    );

    assign cur_mask   = mode_ff[EXC_W-1:0];
    assign push_slot  = top_ff - 3'h1;
    assign res_slot   = top_ff + result_slot;
    // simultaneous push and pop replaces the top in place
    assign push_fault = push_valid && !pop_valid && (tag_ff[push_slot*TAG_W +: TAG_W] != TAG_EMPTY);
    assign pop_fault  = pop_valid && (tag_ff[top_ff*TAG_W +: TAG_W] == TAG_EMPTY);
    assign stack_err  = push_fault || pop_fault;
    assign hw_exc     = (exc_valid ? exc_flags : 6'h00) | {5'h00, stack_err};
    assign unmasked   = |(hw_exc & ~cur_mask);
    assign masked_only = (hw_exc != 6'h00) && !unmasked;

    ////////////////////////////////////////////////////////////////////////////////
    // bus write decode
    logic                wr_fire;
    logic                wr_hit;
    logic                wr_tag;
    logic                wr_status;
    logic                wr_mode;
    logic                wr_istat;
    logic                wr_imask;
    logic [REG_W-1:0]    wr_tag_val;
    logic [REG_W-1:0]    wr_status_val;
    logic [REG_W-1:0]    wr_mode_val;

    function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] data,
                                                 input logic [3:0] strb);
        return {strb[1] ? data[15:8] : old_v[15:8], strb[0] ? data[7:0] : old_v[7:0]};
    endfunction

    assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_tag        = wr_fire && (aw_addr_ff == OFS_TAG);
    assign wr_status     = wr_fire && (aw_addr_ff == OFS_STATUS);
    assign wr_mode       = wr_fire && (aw_addr_ff == OFS_MODE);
    assign wr_istat      = wr_fire && (aw_addr_ff == OFS_IRQ_STAT);
    assign wr_imask      = wr_fire && (aw_addr_ff == OFS_IRQ_MASK);
    assign wr_hit        = wr_tag || wr_status || wr_mode || wr_istat || wr_imask;
    assign wr_tag_val    = merge16(tag_ff, w_data_ff, w_strb_ff);
    assign wr_status_val = merge16(status_ff, w_data_ff, w_strb_ff);
    assign wr_mode_val   = merge16(mode_ff, w_data_ff, w_strb_ff) & MODE_WR_MASK;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid  = 1'b0;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready  = !nxt_w_held && !nxt_bvalid;
    end

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
                OFS_TAG:      nxt_rdata = {16'h0000, tag_ff};
                OFS_STATUS:   nxt_rdata = {16'h0000, status_ff};
                OFS_MODE:     nxt_rdata = {16'h0000, mode_ff};
                OFS_IRQ_STAT: nxt_rdata = {29'h00000000, irq_stat_ff};
                OFS_IRQ_MASK: nxt_rdata = {29'h00000000, irq_mask_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tag word, one field per data register
    logic [IDX_W-1:0] top_base;
    assign top_base = wr_status ? wr_status_val[ST_TOP_LSB +: IDX_W] : top_ff;

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_tag
            always_comb begin
                nxt_tag[i*TAG_W +: TAG_W] = wr_tag ? wr_tag_val[i*TAG_W +: TAG_W] : tag_ff[i*TAG_W +: TAG_W];
                if (push_valid && pop_valid && (top_ff == IDX_W'(i))) begin
                    nxt_tag[i*TAG_W +: TAG_W] = load_class;
                end else if (push_valid && (push_slot == IDX_W'(i))) begin
                    nxt_tag[i*TAG_W +: TAG_W] = load_class;
                end else if (pop_valid && (top_ff == IDX_W'(i))) begin
                    nxt_tag[i*TAG_W +: TAG_W] = TAG_EMPTY;
                end
                if (result_valid && (res_slot == IDX_W'(i))) begin
                    nxt_tag[i*TAG_W +: TAG_W] = load_class;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // status and mode words
    always_comb begin
        nxt_cc  = cc_ff;
        nxt_top = top_base;
        nxt_es  = es_ff;
        nxt_sf  = sf_ff;
        nxt_exc = exc_ff;
        if (wr_status) begin
            nxt_cc  = {wr_status_val[ST_CC3], wr_status_val[ST_CC_LO_LSB +: 3]};
            nxt_es  = wr_status_val[ST_ES];
            nxt_sf  = wr_status_val[ST_SF];
            nxt_exc = wr_status_val[EXC_W-1:0];
        end
        if (cc_valid) begin
            nxt_cc = cc_value;
        end
        if (push_valid && !pop_valid) begin
            nxt_top = top_ff - 3'h1;
        end else if (pop_valid && !push_valid) begin
            nxt_top = top_ff + 3'h1;
        end
        if (stack_err) begin
            nxt_sf = 1'b1;
        end
        nxt_exc = nxt_exc | hw_exc;
        if (unmasked) begin
            nxt_es = 1'b1;
        end
        nxt_status = {nxt_es, nxt_cc[3], nxt_top, nxt_cc[2:0],
                      nxt_es, nxt_sf, nxt_exc};
        nxt_trap   = unmasked;
    end

    always_comb begin
        nxt_mode = mode_ff;
        if (wr_mode) begin
            nxt_mode = wr_mode_val;
            // a reserved precision code leaves the old precision in force
            if (wr_mode_val[MODE_PREC_LSB +: 2] == PREC_RSVD) begin
                nxt_mode[MODE_PREC_LSB +: 2] = mode_ff[MODE_PREC_LSB +: 2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        nxt_irq_mask = irq_mask_ff;
        if (wr_istat) begin
            nxt_irq_stat = irq_stat_ff & ~w_data_ff[IRQ_W-1:0];
        end
        if (wr_imask) begin
            nxt_irq_mask = w_data_ff[IRQ_W-1:0];
        end
        // events win over a clear in the same cycle
        nxt_irq_stat[IRQ_TRAP]   = nxt_irq_stat[IRQ_TRAP] | unmasked;
        nxt_irq_stat[IRQ_STACK]  = nxt_irq_stat[IRQ_STACK] | stack_err;
        nxt_irq_stat[IRQ_MASKED] = nxt_irq_stat[IRQ_MASKED] | masked_only;
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff  <= 1'b0;
            wready_ff   <= 1'b0;
            aw_held_ff  <= 1'b0;
            aw_addr_ff  <= 8'h00;
            w_held_ff   <= 1'b0;
            w_data_ff   <= 32'h00000000;
            w_strb_ff   <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
            arready_ff  <= 1'b0;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 32'h00000000;
            rresp_ff    <= RESP_OKAY;
            tag_ff      <= TAG_RST;
            cc_ff       <= 4'h0;
            top_ff      <= 3'h0;
            es_ff       <= 1'b0;
            sf_ff       <= 1'b0;
            exc_ff      <= 6'h00;
            status_ff   <= STATUS_RST;
            mode_ff     <= MODE_RST;
            trap_ff     <= 1'b0;
            irq_stat_ff <= 3'h0;
            irq_mask_ff <= IRQ_MASK_RST;
            irq_ff      <= 1'b0;
        end else begin
            awready_ff  <= nxt_awready;
            wready_ff   <= nxt_wready;
            aw_held_ff  <= nxt_aw_held;
            aw_addr_ff  <= nxt_aw_addr;
            w_held_ff   <= nxt_w_held;
            w_data_ff   <= nxt_w_data;
            w_strb_ff   <= nxt_w_strb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            arready_ff  <= nxt_arready;
            rvalid_ff   <= nxt_rvalid;
            rdata_ff    <= nxt_rdata;
            rresp_ff    <= nxt_rresp;
            tag_ff      <= nxt_tag;
            cc_ff       <= nxt_cc;
            top_ff      <= nxt_top;
            es_ff       <= nxt_es;
            sf_ff       <= nxt_sf;
            exc_ff      <= nxt_exc;
            status_ff   <= nxt_status;
            mode_ff     <= nxt_mode;
            trap_ff     <= nxt_trap;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff      <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rdata      = rdata_ff;
    assign s_axi_rresp      = rresp_ff;
    assign trap_req         = trap_ff;
    assign rounding_select  = mode_ff[MODE_RND_LSB +: 2];
    assign precision_select = mode_ff[MODE_PREC_LSB +: 2];
    assign exc_mask         = mode_ff[EXC_W-1:0];
    assign stack_top        = top_ff;
    assign tag_word         = tag_ff;
    assign status_word      = status_ff;
    assign irq              = irq_ff;

endmodule // fp_unit_tag_status_control_regs

// ===== shared/fpu_regs_pkg.sv
// constants, field layout and types of the floating point tag, status and mode control register bank
// assumes one core clock; register offsets are byte addresses on a 32-bit AXI4-Lite slave
package fpu_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // bus
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 16;
    localparam logic [7:0]  OFS_TAG       = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_MODE      = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h10;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // tag word
    localparam int          TAG_W         = 2;
    localparam int          NUM_REGS      = 8;
    localparam int          IDX_W         = 3;
    localparam logic [15:0] TAG_RST       = 16'hFFFF;

    typedef enum logic [1:0] {
        TAG_VALID   = 2'h0,
        TAG_ZERO    = 2'h1,
        TAG_SPECIAL = 2'h2,
        TAG_EMPTY   = 2'h3
    } tag_class_e;

    ////////////////////////////////////////////////////////////////////////////////
    // status word
    localparam int          ST_BUSY       = 15;
    localparam int          ST_CC3        = 14;
    localparam int          ST_TOP_LSB    = 11;
    localparam int          ST_CC_LO_LSB  = 8;
    localparam int          ST_ES         = 7;
    localparam int          ST_SF         = 6;
    localparam int          EXC_W         = 6;
    localparam int          EXC_PE        = 5;
    localparam int          EXC_UE        = 4;
    localparam int          EXC_OE        = 3;
    localparam int          EXC_ZE        = 2;
    localparam int          EXC_DE        = 1;
    localparam int          EXC_IE        = 0;
    localparam logic [15:0] STATUS_RST    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    // mode control word
    localparam int          MODE_RND_LSB  = 10;
    localparam int          MODE_PREC_LSB = 8;
    localparam logic [15:0] MODE_WR_MASK  = 16'h0F3F;
    localparam logic [15:0] MODE_RST      = 16'h033F;

    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_DOWN    = 2'h1,
        RND_UP      = 2'h2,
        RND_TRUNC   = 2'h3
    } rounding_e;

    typedef enum logic [1:0] {
        PREC_24     = 2'h0,
        PREC_RSVD   = 2'h1,
        PREC_53     = 2'h2,
        PREC_64     = 2'h3
    } precision_e;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_TRAP      = 0;
    localparam int          IRQ_STACK     = 1;
    localparam int          IRQ_MASKED    = 2;
    localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // extended operand layout
    localparam int          OPND_W        = 80;
    localparam int          EXP_W         = 15;
    localparam int          EXP_LSB       = 64;
    localparam int          INT_BIT       = 63;
    localparam logic [14:0] EXP_MAX       = 15'h7FFF;

endpackage

// ===== hw/tag_classifier.sv
// classifies one extended-precision operand into its two-bit tag class
// assumes an 80-bit operand: sign, 15-bit exponent, explicit integer bit, 63-bit fraction
`timescale 1ns/100ps
module tag_classifier
    import fpu_regs_pkg::*;
(
    input  wire logic [OPND_W-1:0] operand,   // value being loaded
    output tag_class_e             tag_class  // class code for the tag word
);

    logic [EXP_W-1:0] exponent;
    logic             int_bit;
    logic             mant_zero;

    assign exponent  = operand[EXP_LSB +: EXP_W];
    assign int_bit   = operand[INT_BIT];
    assign mant_zero = (operand[INT_BIT:0] == 64'h0000000000000000);

    always_comb begin
        if (exponent == 15'h0000 && mant_zero) begin
            tag_class = TAG_ZERO;
        end else if (exponent == 15'h0000) begin
            tag_class = TAG_SPECIAL;
        end else if (exponent == EXP_MAX) begin
            tag_class = TAG_SPECIAL;
        end else if (!int_bit) begin
            tag_class = TAG_SPECIAL;
        end else begin
            tag_class = TAG_VALID;
        end
    end

endmodule // tag_classifier

// ===== testbench/fp_regs_asserts.sv
// port assertions for the floating point register bank
// assumes one clock aclk and the synchronous active-low aresetn
`timescale 1ns/100ps
module fp_regs_asserts
    import fpu_regs_pkg::*;
(
    input wire logic               aclk,             // clock
    input wire logic               aresetn,          // reset
    input wire logic               push_valid,       // push
    input wire logic               pop_valid,        // pop
    input wire logic               result_valid,     // result write
    input wire logic [IDX_W-1:0]   result_slot,      // result slot
    input wire logic [OPND_W-1:0]  operand,          // value
    input wire logic               exc_valid,        // exception
    input wire logic [EXC_W-1:0]   exc_flags,        // flags
    input wire logic               cc_valid,         // cc strobe
    input wire logic [3:0]         cc_value,         // cc value
    input wire logic               trap_req,         // trap
    input wire logic [1:0]         precision_select, // precision
    input wire logic [EXC_W-1:0]   exc_mask,         // masks
    input wire logic [IDX_W-1:0]   stack_top,        // top
    input wire logic [REG_W-1:0]   tag_word,         // tags
    input wire logic [REG_W-1:0]   status_word       // status
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_busy_mirror: assert property (status_word[ST_BUSY] == status_word[ST_ES]) else $error("busy mirror");
    a_top_field: assert property (status_word[13:11] == stack_top) else $error("top field");
    a_cc_place: assert property (cc_valid |=> {status_word[14], status_word[10:8]} == $past(cc_value))
        else $error("cc place");
    a_es_set: assert property (exc_valid && |(exc_flags & ~exc_mask) |=> status_word[ST_ES]) else $error("es");
    a_trap_report: assert property (exc_valid && !push_valid && !pop_valid
        |=> trap_req == |($past(exc_flags) & ~$past(exc_mask))) else $error("trap");
    a_sticky_flags: assert property (exc_valid |=> (status_word[5:0] & $past(exc_flags)) == $past(exc_flags))
        else $error("flags");
    a_stack_fault: assert property (push_valid && !pop_valid
        && tag_word[{3'(stack_top - 3'h1), 1'b0} +: 2] != 2'h3 |=> status_word[ST_SF] && status_word[EXC_IE])
        else $error("stack fault");
    a_prec_legal: assert property (precision_select != 2'h1) else $error("precision");
    a_push_top: assert property (push_valid && !pop_valid |=> stack_top == 3'($past(stack_top) - 3'h1))
        else $error("push top");
    a_pop_empty: assert property (pop_valid && !push_valid
        |=> tag_word[{$past(stack_top), 1'b0} +: 2] == 2'h3) else $error("pop tag");
    a_push_special: assert property (push_valid && !pop_valid && operand[78:64] == EXP_MAX
        |=> tag_word[{stack_top, 1'b0} +: 2] == 2'h2) else $error("special");
    a_result_tag: assert property (result_valid && !push_valid && !pop_valid && operand[78:0] == 79'h0
        |=> tag_word[{3'($past(stack_top) + $past(result_slot)), 1'b0} +: 2] == 2'h1) else $error("result tag");
endmodule // fp_regs_asserts
////////////////////////////////////////////////////////////////////////////////
bind fp_unit_tag_status_control_regs fp_regs_asserts fp_regs_asserts_inst (.aclk, .aresetn, .push_valid,
    .pop_valid, .result_valid, .result_slot, .operand, .exc_valid, .exc_flags, .cc_valid, .cc_value, .trap_req,
    .precision_select, .exc_mask, .stack_top, .tag_word, .status_word);

// ===== testbench/fp_unit_tag_status_control_regs_tb.sv
// self-checking bench for the floating point register bank
// assumes an AXI4-Lite slave and core strobes taken on every rising aclk edge
`timescale 1ns/100ps
module fp_unit_tag_status_control_regs_tb import fpu_regs_pkg::*;;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic push_valid, pop_valid, result_valid, exc_valid, cc_valid, s_axi_bvalid, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, trap_req, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rounding_select, precision_select;
    logic [5:0]  exc_flags, exc_mask;
    logic [3:0]  cc_value, s_axi_wstrb;
    logic [2:0]  result_slot, stack_top;
    logic [15:0] tag_word, status_word;
    logic [79:0] operand;
    logic [33:0] q[$];
    int          err_count, check_count, cyc;
    fp_unit_tag_status_control_regs fp_unit_tag_status_control_regs_inst (.*);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        if (q.size() != 0) err_count++;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [33:0] e = 34'h0);
        @(posedge aclk);
        q.push_back(e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        q.push_back(e);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
    always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, s_axi_bresp}, q.pop_front());
    always @(posedge aclk) if (++cyc > 3000) begin err_count++; finish_test; end
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {push_valid, pop_valid, result_valid, exc_valid, cc_valid, result_slot, operand} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, exc_flags, cc_value} = '0;
        s_axi_wstrb = 4'hF;
        r = 32'h29BC9F16;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_TAG, 34'h0FFFF);
        rd(OFS_STATUS, 34'h0);
        rd(OFS_MODE, 34'h0033F);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_MODE, 32'h0000F3FF | (i << 10));
            chk("rounding", {32'h0, rounding_select}, 34'(i));
            rd(OFS_MODE, 34'h0033F | (i << 10));
        end
        wr(OFS_MODE, 32'h100);
        chk("precision", {32'h0, precision_select}, 34'h3);
        chk("mask", {28'h0, exc_mask}, 34'h0);
        rd(OFS_MODE, 34'h300);
        wr(8'h14, 32'h1, 34'h2);
        rd(8'h14, 34'h200000000);
        wr(OFS_IRQ_MASK, 32'h1);
        @(posedge aclk);
        exc_valid <= 1'b1;
        exc_flags <= 6'h04;
        @(posedge aclk);
        exc_valid <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h1);
        rd(OFS_STATUS, 34'h08084);
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq", {33'h0, irq}, 34'h0);
        wr(OFS_IRQ_STAT, 32'h1);
        rd(OFS_IRQ_STAT, 34'h0);
        repeat (300) begin
            @(posedge aclk);
            r = lfsr(r);
            {push_valid, pop_valid, exc_valid, cc_valid, cc_value, exc_flags} <= {r[3:0], r[7:4], r[13:8]};
            // results only in cycles without push or pop
            {result_valid, result_slot} <= {r[14] & ~r[3] & ~r[2], r[17:15]};
            operand <= {r[31], r[5] ? 15'h7FFF : r[30:16] & {15{~r[6]}}, r[6] ? 64'h0 : {r, r}};
        end
        @(posedge aclk);
        {push_valid, pop_valid, result_valid, exc_valid, cc_valid} <= 5'h0;
        finish_test;
    end
endmodule // fp_unit_tag_status_control_regs_tb
